// [rtl/rtk_core.sv]
// Timekeeping core: serial slave, BCD clock/calendar, power-fail gate.
// Assumes SCL, SDA, oscillator and power-fail arrive asynchronously
// and that the wire level of SDA is resolved outside from the enable.
`timescale 1ns/1ps
module rtk_core import rtk_pkg::*; #(
    // Slave identity, arbitrary value
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    // Recovery interval in core cycles
    parameter logic [31:0] REC_CYCLES = 32'(REC_TIME_US * CLK_MHZ)
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Oscillator and supply sense
    input wire logic osc_clk_in,
    input wire logic power_fail_in,
    // Square-wave output
    input wire logic sqw_enable_in,
    output logic square_wave_irq_out,
    output logic square_wave_irq_oe_out,
    // Status
    output logic access_blocked_out
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // BCD increment from lo to hi; bit 8 flags the wrap
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                            input logic [7:0] hi);
        if (v >= hi) begin
            return {1'b1, lo};
        end else if (v[3:0] >= 4'h9) begin
            return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        end
        return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction

    // Last date of the month, February set by century flag
    function automatic logic [7:0] month_end(input logic [4:0] mon, input logic cent);
        case (mon)
            5'h02: return cent ? 8'h28 : 8'h29;
            5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    // Pointer advance with wrap past the last location
    function automatic logic [4:0] ptr_next(input logic [4:0] p);
        return (p >= ADDR_LAST) ? ADDR_SEC : 5'(p + 5'h01);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    rtk_state_t st_q; // All registered state
    rtk_state_t st_d; // Next state
    logic scl; // Synchronised SCL
    logic sda; // Synchronised SDA
    logic scl_rise; // SCL edge events
    logic scl_fall;
    logic start_ev; // Bus conditions
    logic stop_ev;
    logic tick; // One-second tick
    logic blocked; // Access gate
    logic [8:0] r; // Scratch step result
    logic carry; // Carry between fields
    logic [7:0] hr; // Hours scratch
    logic [7:0] rbyte; // Byte at the pointer for reads
    logic [4:0] np; // Next pointer

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        r = '0;
        hr = '0;
        carry = 1'b0;
        np = ptr_next(st_q.ptr);
        // Two-stage synchronisers; only the second stage (bit 1) is read by logic
        st_d.scl_sync = {st_q.scl_sync[0], scl_in};
        st_d.sda_sync = {st_q.sda_sync[0], sda_in};
        st_d.osc_sync = {st_q.osc_sync[0], osc_clk_in};
        st_d.pf_sync = {st_q.pf_sync[0], power_fail_in};
        scl = st_q.scl_sync[1];
        sda = st_q.sda_sync[1];
        st_d.scl_prev = scl;
        st_d.sda_prev = sda;
        st_d.osc_prev = st_q.osc_sync[1];
        scl_rise = scl & ~st_q.scl_prev;
        scl_fall = ~scl & st_q.scl_prev;
        start_ev = scl & st_q.scl_prev & st_q.sda_prev & ~sda;
        stop_ev = scl & st_q.scl_prev & ~st_q.sda_prev & sda;

        // Oscillator edges feed the divider chain, counting up
        tick = 1'b0;
        if (st_q.osc_sync[1] & ~st_q.osc_prev) begin
            st_d.div = 15'(st_q.div + 15'h0001);
            tick = (st_q.div == DIV_MAX);
        end

        // Seconds to years carry chain in BCD
        if (tick) begin
            r = bcd_step(st_q.tm[SEC_I], 8'h00, 8'h59);
            st_d.tm[SEC_I] = r[7:0];
            if (r[8]) begin
                r = bcd_step(st_q.tm[MIN_I], 8'h00, 8'h59);
                st_d.tm[MIN_I] = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                hr = st_q.tm[HOUR_I];
                carry = 1'b0;
                if (hr[HOUR_12_BIT]) begin
                    // Twelve-hour: 11 to 12 flips PM, 12 to 01
                    if (hr[4:0] == 5'h12) begin
                        hr[4:0] = 5'h01;
                    end else if (hr[4:0] == 5'h11) begin
                        hr[4:0] = 5'h12;
                        carry = hr[HOUR_PM_BIT];
                        hr[HOUR_PM_BIT] = ~hr[HOUR_PM_BIT];
                    end else begin
                        r = bcd_step({3'h0, hr[4:0]}, 8'h01, 8'h12);
                        hr[4:0] = r[4:0];
                    end
                end else begin
                    // Twenty-four-hour: bit 5 is the twenties digit
                    r = bcd_step({2'h0, hr[5:0]}, 8'h00, 8'h23);
                    hr[5:0] = r[5:0];
                    carry = r[8];
                end
                st_d.tm[HOUR_I] = hr;
            end
            if (carry) begin
                r = bcd_step(st_q.tm[DAY_I], 8'h01, 8'h07);
                st_d.tm[DAY_I] = r[7:0];
                r = bcd_step(st_q.tm[DATE_I], 8'h01,
                             month_end(st_q.tm[MON_I][4:0], st_q.tm[MON_I][CENTURY_BIT]));
                st_d.tm[DATE_I] = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_step({3'h0, st_q.tm[MON_I][4:0]}, 8'h01, 8'h12);
                st_d.tm[MON_I][4:0] = r[4:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_step(st_q.tm[YEAR_I], 8'h00, 8'h99);
                st_d.tm[YEAR_I] = r[7:0];
                if (r[8]) begin
                    st_d.tm[MON_I][CENTURY_BIT] = ~st_q.tm[MON_I][CENTURY_BIT];
                end
            end
        end

        // Power-fail gate with recovery hold-off
        if (st_q.pf_sync[1]) begin
            st_d.rec_cnt = REC_CYCLES;
        end else if (st_q.rec_cnt != 32'h0) begin
            st_d.rec_cnt = 32'(st_q.rec_cnt - 32'h1);
        end
        blocked = st_q.pf_sync[1] | (st_q.rec_cnt != 32'h0);
        st_d.blocked = blocked;

        // Square wave low for the first half second of the chain
        st_d.sqw_oe = sqw_enable_in & ~st_d.div[SQW_HALF_BIT];

        // Byte presented for reads: shadows for time, else storage
        if (st_q.ptr < 5'(NUM_TIME)) begin
            rbyte = st_q.shadow[st_q.ptr[2:0]];
        end else begin
            rbyte = st_q.aux[4'(st_q.ptr - AUX_BASE)];
        end

        // Serial slave
        if (start_ev) begin
            st_d.i2c = ST_ADDR;
            st_d.bits = 4'h0;
            st_d.sda_oe = 1'b0;
            st_d.shadow = st_q.tm;
        end else if (stop_ev) begin
            st_d.i2c = ST_IDLE;
            st_d.sda_oe = 1'b0;
        end else begin
            case (st_q.i2c)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        st_d.shift = {st_q.shift[6:0], sda};
                        st_d.bits = 4'(st_q.bits + 4'h1);
                    end else if (scl_fall && st_q.bits == 4'h8) begin
                        st_d.sda_oe = 1'b1;
                        if (st_q.i2c == ST_ADDR) begin
                            st_d.rd = st_q.shift[0];
                            // Wrong identity, or a read while blocked: no ack
                            if (st_q.shift[7:1] != DEV_ADDR || (st_q.shift[0] && blocked)) begin
                                st_d.sda_oe = 1'b0;
                                st_d.i2c = ST_IDLE;
                            end else begin
                                st_d.i2c = ST_ADDR_ACK;
                            end
                        end else if (st_q.i2c == ST_PTR) begin
                            st_d.ptr = (st_q.shift[4:0] > ADDR_LAST || st_q.shift[7:5] != 3'h0)
                                       ? ADDR_SEC : st_q.shift[4:0];
                            st_d.i2c = ST_PTR_ACK;
                        end else begin
                            // Commit as the device ack starts
                            if (!blocked) begin
                                if (st_q.ptr < 5'(NUM_TIME)) begin
                                    st_d.tm[st_q.ptr[2:0]] = st_q.shift &
                                                             TIME_MASK[st_q.ptr[2:0]];
                                end else begin
                                    st_d.aux[4'(st_q.ptr - AUX_BASE)] = st_q.shift;
                                end
                                if (st_q.ptr == ADDR_SEC) begin
                                    st_d.div = '0;
                                end
                            end
                            st_d.ptr = np;
                            if (np == ADDR_SEC) begin
                                st_d.shadow = st_d.tm;
                            end
                            st_d.i2c = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        st_d.bits = 4'h0;
                        if (st_q.rd) begin
                            st_d.shift = rbyte;
                            st_d.sda_oe = ~rbyte[7];
                            st_d.bits = 4'h1;
                            st_d.i2c = ST_RDATA;
                        end else begin
                            st_d.sda_oe = 1'b0;
                            st_d.i2c = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        st_d.sda_oe = 1'b0;
                        st_d.bits = 4'h0;
                        st_d.i2c = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (st_q.bits == 4'h8) begin
                            st_d.sda_oe = 1'b0;
                            st_d.ptr = np;
                            if (np == ADDR_SEC) begin
                                st_d.shadow = st_q.tm;
                            end
                            st_d.i2c = ST_RDATA_ACK;
                        end else begin
                            st_d.shift = {st_q.shift[6:0], 1'b0};
                            st_d.sda_oe = ~st_q.shift[6];
                            st_d.bits = 4'(st_q.bits + 4'h1);
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        st_d.acked = ~sda;
                    end else if (scl_fall) begin
                        if (st_q.acked && !blocked) begin
                            st_d.shift = rbyte;
                            st_d.sda_oe = ~rbyte[7];
                            st_d.bits = 4'h1;
                            st_d.i2c = ST_RDATA;
                        end else begin
                            st_d.i2c = ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_d.i2c = ST_IDLE;
                    st_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q <= '0;
            st_q.tm <= TIME_INIT;
            st_q.shadow <= TIME_INIT;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = st_q.sda_oe;
    assign square_wave_irq_out = 1'b0;
    assign square_wave_irq_oe_out = st_q.sqw_oe;
    assign access_blocked_out = st_q.blocked;
endmodule

// [rtl/rtk_pkg.sv]
// Constants, types and state layout of the timekeeping core.
// Assumes a 100 MHz core clock; all pins arrive from outside its domain.
package rtk_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [4:0] ADDR_SEC = 5'h00;
    localparam logic [4:0] ADDR_LAST = 5'h10;
    localparam logic [4:0] AUX_BASE = 5'h07;
    localparam int NUM_TIME = 7;
    localparam int NUM_AUX = 10;
    localparam int SEC_I = 0;
    localparam int MIN_I = 1;
    localparam int HOUR_I = 2;
    localparam int DAY_I = 3;
    localparam int DATE_I = 4;
    localparam int MON_I = 5;
    localparam int YEAR_I = 6;
    localparam int HOUR_12_BIT = 6;
    localparam int HOUR_PM_BIT = 5;
    localparam int CENTURY_BIT = 7;
    // Writable bits of each time register; the rest read as zero
    localparam logic [6:0][7:0] TIME_MASK = {8'hff, 8'h9f, 8'h3f, 8'h07, 8'h7f, 8'h7f, 8'h7f};
    // Year 00, month 01, date 01, weekday 01, 00:00:00
    localparam logic [6:0][7:0] TIME_INIT = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int REC_TIME_US = 250;
    localparam logic [14:0] DIV_MAX = 15'h7fff;
    localparam int SQW_HALF_BIT = 14;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PTR_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } rtk_i2c_t;
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] osc_sync;
        logic [1:0] pf_sync;
        logic scl_prev;
        logic sda_prev;
        logic osc_prev;
        logic [31:0] rec_cnt;
        rtk_i2c_t i2c;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [4:0] ptr;
        logic rd;
        logic acked;
        logic sda_oe;
        logic sqw_oe;
        logic blocked;
        logic [6:0][7:0] tm;
        logic [6:0][7:0] shadow;
        logic [9:0][7:0] aux;
        logic [14:0] div;
    } rtk_state_t;
endpackage

// [sim/rtk_core_assertions.sv]
// Concurrent checks on the pins of the timekeeping core.
// Assumes the bench holds each bus clock phase for at least four core cycles.
`timescale 1ns/1ps
module rtk_core_checker #(
    parameter logic [31:0] REC_CYCLES = 32'h14
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Serial bus, oscillator and supply sense
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic osc_clk_in,
    input wire logic power_fail_in,
    // Square wave and status
    input wire logic sqw_enable_in,
    input wire logic square_wave_irq_out,
    input wire logic square_wave_irq_oe_out,
    input wire logic access_blocked_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // ----------------------------------------
    // Helper: cycles since the supply sense last read high, saturating
    // ----------------------------------------
    logic [31:0] quiet_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            quiet_q <= 32'hffffffff;
        end else if (power_fail_in) begin
            quiet_q <= 32'h0;
        end else if (quiet_q != 32'hffffffff) begin
            quiet_q <= quiet_q + 32'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_sda_low; sda_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda data value not low");
    property p_oe_scl; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("sda pull changed with scl high");
    property p_oe_rel; $rose(sda_oe_out) |-> ##[1:200] !sda_oe_out; endproperty
    a_oe_rel: assert property (p_oe_rel) else $error("sda pull never released");
    property p_pf_block; power_fail_in [*4] |-> access_blocked_out; endproperty
    a_pf_block: assert property (p_pf_block) else $error("access open in power fail");
    property p_pf_cause;
        $rose(access_blocked_out) |-> $past(power_fail_in, 2) || $past(power_fail_in, 3);
    endproperty
    a_pf_cause: assert property (p_pf_cause) else $error("blocked without power fail");
    property p_rec_hold; quiet_q == REC_CYCLES |-> access_blocked_out; endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("recovery ended early");
    property p_rec_end; quiet_q > REC_CYCLES + 32'h8 |-> !access_blocked_out; endproperty
    a_rec_end: assert property (p_rec_end) else $error("recovery never ended");
    property p_sqw_off; !sqw_enable_in |=> !square_wave_irq_oe_out; endproperty
    a_sqw_off: assert property (p_sqw_off) else $error("square wave pulls while off");
    property p_sqw_low; square_wave_irq_out == 1'b0; endproperty
    a_sqw_low: assert property (p_sqw_low) else $error("square wave data not low");
endmodule
bind rtk_core rtk_core_checker #(.REC_CYCLES(REC_CYCLES)) rtk_core_checker_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .osc_clk_in(osc_clk_in),
    .power_fail_in(power_fail_in), .sqw_enable_in(sqw_enable_in),
    .square_wave_irq_out(square_wave_irq_out), .square_wave_irq_oe_out(square_wave_irq_oe_out),
    .access_blocked_out(access_blocked_out));

// [sim/rtk_core_test.sv]
// Self-checking bench of the timekeeping core against a register model.
// Assumes the master model drives the bus; the data wire has a pull-up.
`timescale 1ns/1ps
module rtk_core_test;
    import rtk_pkg::*;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    localparam logic [6:0] ADDR = 7'h2a; // Arbitrary slave identity
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic osc_clk_in = 1'b0;
    logic power_fail_in = 1'b0;
    logic sqw_enable_in = 1'b0;
    logic scl_in, sda_in, sda_out, sda_oe_out, sda_low, sqw_out, sqw_oe, blocked, ack;
    logic [7:0] rb;
    logic [7:0] mdl [0:16]; // Register model
    logic [31:0] seed = 32'd97460;
    int n_errors = 0;
    int total_checks = 0;
    assign sda_in = !(sda_low | sda_oe_out); // Pulled-up wire
    rtk_core #(.DEV_ADDR(ADDR), .REC_CYCLES(32'h14)) rtk_core_inst (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .osc_clk_in(osc_clk_in),
        .power_fail_in(power_fail_in), .sqw_enable_in(sqw_enable_in),
        .square_wave_irq_out(sqw_out), .square_wave_irq_oe_out(sqw_oe),
        .access_blocked_out(blocked));
    rtk_i2c_master rtk_i2c_master_inst (.core_clk_in(core_clk_in), .sda_wire_in(sda_in),
        .scl_out(scl_in), .sda_low_out(sda_low));
    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] binc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // START and identity byte with direction bit
    task automatic open(input logic rd_bit, input logic exp_ack);
        rtk_i2c_master_inst.start_cond();
        rtk_i2c_master_inst.send_byte({ADDR, rd_bit}, ack);
        chk("address ack", {7'h0, ack}, {7'h0, exp_ack});
    endtask
    // Write a run from pointer p; writes during power fail leave the model alone
    task automatic wr(input int p, input logic [7:0] d[$]);
        open(1'b0, 1'b1);
        rtk_i2c_master_inst.send_byte(8'(p), ack);
        foreach (d[i]) begin
            rtk_i2c_master_inst.send_byte(d[i], ack);
            chk("write ack", {7'h0, ack}, 8'h01);
            if (!power_fail_in) mdl[p] = (p < NUM_TIME) ? d[i] & TIME_MASK[p] : d[i];
            p = (p == 16) ? 0 : p + 1;
        end
        rtk_i2c_master_inst.stop_cond();
    endtask
    // Read n bytes from pointer p after a repeated START
    task automatic rd(input int p, input int n);
        open(1'b0, 1'b1);
        rtk_i2c_master_inst.send_byte(8'(p), ack);
        open(1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            rtk_i2c_master_inst.recv_byte(rb, i == n - 1);
            chk("read byte", rb, mdl[p]);
            p = (p == 16) ? 0 : p + 1;
        end
        rtk_i2c_master_inst.stop_cond();
    endtask
    // Oscillator edges, one core cycle per level
    task automatic osc_run(input int n);
        repeat (n) begin
            osc_clk_in <= 1'b1;
            cyc(1);
            osc_clk_in <= 1'b0;
            cyc(1);
        end
        cyc(8);
    endtask
    // One-second advance of the model calendar, 12-hour or 24-hour mode
    task automatic tick_model();
        logic [7:0] last;
        logic [4:0] mon;
        mdl[0] = (mdl[0] == 8'h59) ? 8'h00 : binc(mdl[0]);
        if (mdl[0] != 8'h00) return;
        mdl[1] = (mdl[1] == 8'h59) ? 8'h00 : binc(mdl[1]);
        if (mdl[1] != 8'h00) return;
        if (mdl[2][6]) begin
            // Twelve-hour: 11 to 12 flips the PM flag, 12 to 01
            if (mdl[2][4:0] == 5'h11) mdl[2] = {mdl[2][7:6], ~mdl[2][5], 5'h12};
            else mdl[2][4:0] = (mdl[2][4:0] == 5'h12) ? 5'h01 : 5'(binc({3'h0, mdl[2][4:0]}));
            if (mdl[2] != 8'h52) return;
        end else begin
            mdl[2] = (mdl[2] == 8'h23) ? 8'h00 : binc(mdl[2]);
            if (mdl[2] != 8'h00) return;
        end
        mdl[3] = (mdl[3] == 8'h07) ? 8'h01 : binc(mdl[3]);
        mon = mdl[5][4:0];
        last = (mon == 5'h02) ? (mdl[5][7] ? 8'h28 : 8'h29) : 8'h31;
        if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) last = 8'h30;
        mdl[4] = (mdl[4] == last) ? 8'h01 : binc(mdl[4]);
        if (mdl[4] != 8'h01) return;
        mdl[5][4:0] = (mon == 5'h12) ? 5'h01 : 5'(binc({3'h0, mon}));
        if (mdl[5][4:0] != 5'h01) return;
        mdl[6] = (mdl[6] == 8'h99) ? 8'h00 : binc(mdl[6]);
        if (mdl[6] == 8'h00) mdl[5][7] = ~mdl[5][7];
    endtask
    // ----------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------
    initial begin
        cyc(90000);
        n_errors++;
        $display("watchdog expired");
        finish_test();
    end
    initial begin
        for (int i = 0; i < 17; i++) mdl[i] = (i < NUM_TIME) ? TIME_INIT[i] : 8'h00;
        cyc(16);
        reset_in <= 1'b0;
        cyc(4);
        rd(0, 7);
        $display("test power-up calendar done");
        rtk_i2c_master_inst.start_cond();
        rtk_i2c_master_inst.send_byte({ADDR ^ 7'h01, 1'b0}, ack);
        chk("foreign id ack", {7'h0, ack}, 8'h00);
        rtk_i2c_master_inst.stop_cond();
        $display("test foreign identity done");
        sqw_enable_in <= 1'b1;
        wr(0, '{8'hd9, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
        rd(0, 7);
        rtk_i2c_master_inst.slow = int'(xorshift() % 32'h4);
        wr(15, '{8'(xorshift()), 8'(xorshift())});
        rd(15, 3);
        $display("test write and wrap done");
        power_fail_in <= 1'b1;
        cyc(6);
        chk("blocked in fail", {7'h0, blocked}, 8'h01);
        wr(2, '{8'h11});
        open(1'b1, 1'b0);
        rtk_i2c_master_inst.stop_cond();
        power_fail_in <= 1'b0;
        cyc(10);
        chk("blocked in recovery", {7'h0, blocked}, 8'h01);
        cyc(30);
        chk("open after recovery", {7'h0, blocked}, 8'h00);
        rd(0, 7);
        $display("test power fail done");
        rtk_i2c_master_inst.slow = 0;
        wr(2, '{8'h71});
        osc_run(100);
        wr(0, '{8'h59});
        osc_run(16383);
        chk("square wave first half", {7'h0, sqw_oe}, 8'h01);
        osc_run(1);
        chk("square wave second half", {7'h0, sqw_oe}, 8'h00);
        osc_run(16383);
        rd(0, 1);
        osc_run(1);
        tick_model();
        rd(0, 7);
        $display("test century rollover done");
        finish_test();
    end
endmodule

// [sim/rtk_i2c_master.sv]
// Serial bus master model driving the bus clock and pulling the data wire.
// Assumes the bench resolves the pulled-up data wire from all pulls.
`timescale 1ns/1ps
module rtk_i2c_master (
    // Clock
    input wire logic core_clk_in,
    // Bus
    input wire logic sda_wire_in,
    output logic scl_out,
    output logic sda_low_out
);
    int slow = 0; // Extra low-phase cycles for a slow master
    // Idle bus: clock high, data released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // START, also a repeated START entered with the clock low
    task automatic start_cond();
        sda_low_out <= 1'b0;
        cyc(4);
        scl_out <= 1'b1;
        cyc(6);
        sda_low_out <= 1'b1;
        cyc(6);
        scl_out <= 1'b0;
        cyc(2);
    endtask
    // STOP ends the sequential run
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        cyc(4);
        scl_out <= 1'b1;
        cyc(6);
        sda_low_out <= 1'b0;
        cyc(6);
    endtask
    // One bit: data set while the clock is low, sampled late in the high phase
    task automatic bit_cycle(input logic b, output logic s);
        sda_low_out <= !b;
        cyc(4 + slow);
        scl_out <= 1'b1;
        cyc(6);
        s = sda_wire_in;
        scl_out <= 1'b0;
        cyc(2);
    endtask
    // Byte out, most significant bit first, then the slave's acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = !s;
    endtask
    // Byte in; a not-acknowledge on the last byte ends the read
    task automatic recv_byte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
        bit_cycle(last, s);
    endtask
endmodule
